// file: slide_pos_pkg.sv
// shared constants and types for the slide actuator position block
// assumes a single 20 MHz clock and an APB register slave
// Contract
// - default soft limits 150mV inside end points
// - percent from soft limits, may overrun
// - decrease output follows held decrease jog
// - increase output follows held increase jog
// - reported position steers forward/reverse drive
// - capture turn count at low/high ends
// - motor drive only while sensor powered
// - after power loss wait stop, save position
// - reload saved position when power returns
// - never stopped means lost, recalibrate
// - first press enters calibration, fast flash
// - second press stores minimum, slow flash
// - third press stores maximum, LED off
// - channel calibrated from stored end points
// - calibration bypasses end stop protection
// - leaving screen calibration returns slide to soft minimum
package slide_pos_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int POS_W  = 16;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_STATUS  = 8'h04;
	localparam logic [7:0] OFS_POS     = 8'h08;
	localparam logic [7:0] OFS_MIN_EP  = 8'h0C;
	localparam logic [7:0] OFS_MAX_EP  = 8'h10;
	localparam logic [7:0] OFS_MIN_LIM = 8'h14;
	localparam logic [7:0] OFS_MAX_LIM = 8'h18;
	localparam logic [7:0] OFS_PCT     = 8'h1C;
	localparam logic [7:0] OFS_TARGET  = 8'h20;
	localparam logic [7:0] OFS_DAC     = 8'h24;
	// status bit positions
	localparam int ST_CAL_MIN = 0;
	localparam int ST_CAL_MAX = 1;
	localparam int ST_LOST    = 2;
	localparam int ST_CALIB   = 3;
	localparam int ST_RETURN  = 4;
	localparam int ST_PWR     = 5;
	localparam int ST_W       = 6;
	// scaling
	localparam int LIM_MV    = 150;
	localparam int FULL_MV   = 5000;
	localparam int PCT_SCALE = 1000;
	localparam int DAC_W     = 12;
	localparam int DAC_FULL  = 4095;
	localparam logic [POS_W-1:0] DEADBAND   = 16'h0002;
	localparam logic [POS_W-1:0] MIN_RST    = 16'h0000;
	localparam logic [POS_W-1:0] MAX_RST    = 16'hFFFF;
	// times in ms and derived cycle counts
	localparam int STOP_QUIET_MS = 50;
	localparam int HOLDUP_MS     = 2000;
	localparam int LED_FAST_MS   = 100;
	localparam int LED_SLOW_MS   = 400;
	localparam int STOP_QUIET_CYC = CLK_HZ / 1000 * STOP_QUIET_MS;
	localparam int HOLDUP_CYC     = CLK_HZ / 1000 * HOLDUP_MS;
	localparam int LED_FAST_CYC   = CLK_HZ / 1000 * LED_FAST_MS;
	localparam int LED_SLOW_CYC   = CLK_HZ / 1000 * LED_SLOW_MS;
	typedef struct packed {
		logic auto_mode;
		logic screen_cal;
		logic jog_inc;
		logic jog_dec;
	} ctrl_t;
	typedef enum logic [2:0] {
		P_RUN  = 3'b000,
		P_STOP = 3'b001,
		P_SAVE = 3'b010,
		P_OFF  = 3'b011,
		P_LOAD = 3'b100
	} pwr_st_t;
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_MIN  = 2'b01,
		C_MAX  = 2'b10
	} cal_st_t;
endpackage

// file: ratio_div.sv
// iterative scaler: quo = num * SCALE / den, signed num
// assumes den nonzero when meaningful; zero den gives zero
`timescale 1ns/1ps
`default_nettype none
module ratio_div #(
	parameter int SCALE = 1000
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// operands
	input  wire logic               start,
	input  wire logic signed [31:0] num,
	input  wire logic        [15:0] den,
	// result
	output logic signed [31:0]      quo,
	output logic                    done
);
	logic [31:0] dvd_r, dvd_nxt;
	logic [16:0] rem_r, rem_nxt;
	logic [15:0] den_r, den_nxt;
	logic [5:0]  cnt_r, cnt_nxt;
	logic        neg_r, neg_nxt, busy_r, busy_nxt, done_nxt;
	logic signed [31:0] quo_nxt;
	logic [16:0] rem_w;
	logic [31:0] mag;

	// restoring division, one quotient bit per clock
	always_comb begin
		mag      = num[31] ? 32'(-num) : num;
		rem_w    = {rem_r[15:0], dvd_r[31]};
		dvd_nxt  = dvd_r;
		rem_nxt  = rem_r;
		den_nxt  = den_r;
		cnt_nxt  = cnt_r;
		neg_nxt  = neg_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		quo_nxt  = quo;
		if (!busy_r) begin
			if (start) begin
				dvd_nxt  = 32'(mag * SCALE);
				rem_nxt  = 17'h00000;
				den_nxt  = den;
				neg_nxt  = num[31];
				cnt_nxt  = 6'h00;
				busy_nxt = 1'b1;
			end
		end else if (cnt_r == 6'h20) begin
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
			if (den_r == 16'h0000)
				quo_nxt = 32'sh0;
			else
				quo_nxt = neg_r ? 32'(-dvd_r) : dvd_r;
		end else begin
			cnt_nxt = cnt_r + 6'h01;
			if (rem_w >= {1'b0, den_r}) begin
				rem_nxt = rem_w - {1'b0, den_r};
				dvd_nxt = {dvd_r[30:0], 1'b1};
			end else begin
				rem_nxt = rem_w;
				dvd_nxt = {dvd_r[30:0], 1'b0};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dvd_r  <= 32'h00000000;
			rem_r  <= 17'h00000;
			den_r  <= 16'h0000;
			cnt_r  <= 6'h00;
			neg_r  <= 1'b0;
			busy_r <= 1'b0;
			done   <= 1'b0;
			quo    <= 32'sh0;
		end else begin
			dvd_r  <= dvd_nxt;
			rem_r  <= rem_nxt;
			den_r  <= den_nxt;
			cnt_r  <= cnt_nxt;
			neg_r  <= neg_nxt;
			busy_r <= busy_nxt;
			done   <= done_nxt;
			quo    <= quo_nxt;
		end
	end
endmodule
`default_nettype wire

// file: slide_pos.sv
// slide actuator position, calibration and power-loss logic
// assumes synchronous pin inputs and an APB master on pclk
`timescale 1ns/1ps
`default_nettype none
module slide_pos #(
	parameter int STOP_CYC = slide_pos_pkg::STOP_QUIET_CYC,
	parameter int HOLD_CYC = slide_pos_pkg::HOLDUP_CYC,
	parameter int FAST_CYC = slide_pos_pkg::LED_FAST_CYC,
	parameter int SLOW_CYC = slide_pos_pkg::LED_SLOW_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// sensor side
	input  wire logic        sensor_pwr_ok,
	input  wire logic        turn_up,
	input  wire logic        turn_dn,
	input  wire logic        cal_btn,
	output logic             led,
	output logic [11:0]      pos_out,
	// motor drive
	output logic             motor_inc,
	output logic             motor_dec,
	// nonvolatile store
	output logic             nvm_wr,
	output logic [15:0]      nvm_wdata,
	output logic             nvm_rd,
	input  wire logic [15:0] nvm_rd_data,
	input  wire logic        nvm_rd_valid
);
	slide_pos_pkg::ctrl_t   ctrl_r, ctrl_nxt;
	slide_pos_pkg::pwr_st_t pst_r, pst_nxt;
	slide_pos_pkg::cal_st_t cst_r, cst_nxt;
	logic [15:0] pos_r, pos_nxt, target_r, target_nxt;
	logic [15:0] min_ep_r, min_ep_nxt, max_ep_r, max_ep_nxt;
	logic [15:0] min_lim_r, min_lim_nxt, max_lim_r, max_lim_nxt;
	logic [31:0] quiet_r, quiet_nxt, hold_r, hold_nxt, led_cnt_r, led_cnt_nxt;
	logic        lost_r, lost_nxt, calib_r, calib_nxt, ret_r, ret_nxt;
	logic        btn_q_r, led_nxt, inc_nxt, dec_nxt, wr_nxt, rd_nxt;
	logic        rdy_nxt, err_nxt;
	logic [31:0] rdata_nxt;
	logic [15:0] wdata_nxt, span, lim_off, pct_r;
	logic [11:0] dac_nxt;
	logic        press, bus_wr, bus_rd, powered, bypass;
	logic        inc_want, dec_want;
	logic signed [31:0] pct_q, dac_q;
	logic        pct_done, dac_done;

	assign press   = cal_btn && !btn_q_r;
	assign bus_wr  = psel && penable && pready && pwrite;
	assign bus_rd  = psel && !penable && !pwrite;
	assign powered = sensor_pwr_ok && (pst_r == slide_pos_pkg::P_RUN);
	// end stop protection is off in either calibration
	assign bypass  = ctrl_r.screen_cal || (cst_r != slide_pos_pkg::C_IDLE);
	assign span    = pos_r - min_ep_r;
	assign lim_off = 16'((32'(span) * slide_pos_pkg::LIM_MV) / slide_pos_pkg::FULL_MV);

	// percent in tenths, relative to the soft limits
	ratio_div #(.SCALE(slide_pos_pkg::PCT_SCALE)) u_pct (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (calib_r),
		.num     (32'(signed'({1'b0, pos_r}) - signed'({1'b0, min_lim_r}))),
		.den     (max_lim_r - min_lim_r),
		.quo     (pct_q),
		.done    (pct_done)
	);

	// analog code, linear between end points
	ratio_div #(.SCALE(slide_pos_pkg::DAC_FULL)) u_dac (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (calib_r),
		.num     (32'(signed'({1'b0, pos_r}) - signed'({1'b0, min_ep_r}))),
		.den     (max_ep_r - min_ep_r),
		.quo     (dac_q),
		.done    (dac_done)
	);

	// apb: answer one cycle into the access phase, no waits
	always_comb begin
		rdy_nxt   = psel && !penable;
		err_nxt   = 1'b0;
		rdata_nxt = 32'h00000000;
		if (psel && !penable) begin
			unique case (paddr)
			slide_pos_pkg::OFS_CTRL:    rdata_nxt = 32'(ctrl_r);
			slide_pos_pkg::OFS_STATUS:  rdata_nxt = 32'({sensor_pwr_ok, ret_r, calib_r, lost_r,
				cst_r == slide_pos_pkg::C_MAX, cst_r == slide_pos_pkg::C_MIN});
			slide_pos_pkg::OFS_POS:     rdata_nxt = 32'(pos_r);
			slide_pos_pkg::OFS_MIN_EP:  rdata_nxt = 32'(min_ep_r);
			slide_pos_pkg::OFS_MAX_EP:  rdata_nxt = 32'(max_ep_r);
			slide_pos_pkg::OFS_MIN_LIM: rdata_nxt = 32'(min_lim_r);
			slide_pos_pkg::OFS_MAX_LIM: rdata_nxt = 32'(max_lim_r);
			slide_pos_pkg::OFS_PCT:     rdata_nxt = 32'(signed'(pct_r));
			slide_pos_pkg::OFS_TARGET:  rdata_nxt = 32'(target_r);
			slide_pos_pkg::OFS_DAC:     rdata_nxt = 32'(pos_out);
			default:                    err_nxt   = 1'b1;
			endcase
		end
		if (!bus_rd)
			rdata_nxt = 32'h00000000;
	end

	// software registers and calibration sequence
	always_comb begin
		ctrl_nxt    = ctrl_r;
		target_nxt  = target_r;
		min_ep_nxt  = min_ep_r;
		max_ep_nxt  = max_ep_r;
		min_lim_nxt = min_lim_r;
		max_lim_nxt = max_lim_r;
		cst_nxt     = cst_r;
		calib_nxt   = calib_r;
		ret_nxt     = ret_r;
		if (bus_wr) begin
			unique case (paddr)
			slide_pos_pkg::OFS_CTRL:    ctrl_nxt    = slide_pos_pkg::ctrl_t'(pwdata[3:0]);
			slide_pos_pkg::OFS_MIN_LIM: min_lim_nxt = pwdata[15:0];
			slide_pos_pkg::OFS_MAX_LIM: max_lim_nxt = pwdata[15:0];
			slide_pos_pkg::OFS_TARGET:  target_nxt  = pwdata[15:0];
			default: ;
			endcase
		end
		// leaving the calibration screen starts the return
		if (ret_r && pos_r <= min_lim_r)
			ret_nxt = 1'b0;
		if (ctrl_r.screen_cal && !ctrl_nxt.screen_cal)
			ret_nxt = 1'b1;
		if (ctrl_nxt.screen_cal)
			ret_nxt = 1'b0;
		unique case (cst_r)
		slide_pos_pkg::C_IDLE: begin
			if (press && powered)
				cst_nxt = slide_pos_pkg::C_MIN;
		end
		slide_pos_pkg::C_MIN: begin
			if (press && powered) begin
				min_ep_nxt = pos_r;
				cst_nxt    = slide_pos_pkg::C_MAX;
			end
		end
		slide_pos_pkg::C_MAX: begin
			if (press && powered) begin
				max_ep_nxt  = pos_r;
				min_lim_nxt = min_ep_r + lim_off;
				max_lim_nxt = pos_r - lim_off;
				calib_nxt   = 1'b1;
				cst_nxt     = slide_pos_pkg::C_IDLE;
			end
		end
		default: cst_nxt = slide_pos_pkg::C_IDLE;
		endcase
		// a lost position forces calibration on power return
		if (pst_r == slide_pos_pkg::P_OFF && sensor_pwr_ok && lost_r) begin
			cst_nxt   = slide_pos_pkg::C_MIN;
			calib_nxt = 1'b0;
		end
	end

	// power-loss handling: wait for stop, save, reload
	always_comb begin
		pst_nxt   = pst_r;
		pos_nxt   = pos_r;
		quiet_nxt = quiet_r;
		hold_nxt  = hold_r;
		lost_nxt  = lost_r;
		wr_nxt    = 1'b0;
		rd_nxt    = 1'b0;
		wdata_nxt = nvm_wdata;
		// sensor circuitry counts while alive on stored energy
		if (pst_r != slide_pos_pkg::P_OFF && pst_r != slide_pos_pkg::P_LOAD) begin
			if (turn_up && !turn_dn)
				pos_nxt = pos_r + 16'h0001;
			else if (turn_dn && !turn_up)
				pos_nxt = pos_r - 16'h0001;
		end
		unique case (pst_r)
		slide_pos_pkg::P_RUN: begin
			quiet_nxt = 32'h00000000;
			hold_nxt  = 32'h00000000;
			if (!sensor_pwr_ok)
				pst_nxt = slide_pos_pkg::P_STOP;
		end
		slide_pos_pkg::P_STOP: begin
			hold_nxt  = hold_r + 32'h00000001;
			quiet_nxt = (turn_up || turn_dn) ? 32'h00000000 : quiet_r + 32'h00000001;
			if (sensor_pwr_ok) begin
				pst_nxt = slide_pos_pkg::P_RUN;
			end else if (quiet_r >= 32'(STOP_CYC - 1)) begin
				pst_nxt = slide_pos_pkg::P_SAVE;
			end else if (hold_r >= 32'(HOLD_CYC - 1)) begin
				lost_nxt = 1'b1;
				pst_nxt  = slide_pos_pkg::P_OFF;
			end
		end
		slide_pos_pkg::P_SAVE: begin
			wr_nxt    = 1'b1;
			wdata_nxt = pos_r;
			lost_nxt  = 1'b0;
			pst_nxt   = slide_pos_pkg::P_OFF;
		end
		slide_pos_pkg::P_OFF: begin
			if (sensor_pwr_ok) begin
				if (lost_r) begin
					lost_nxt = 1'b0;
					pst_nxt  = slide_pos_pkg::P_RUN;
				end else begin
					rd_nxt  = 1'b1;
					pst_nxt = slide_pos_pkg::P_LOAD;
				end
			end
		end
		slide_pos_pkg::P_LOAD: begin
			if (nvm_rd_valid) begin
				pos_nxt = nvm_rd_data;
				pst_nxt = slide_pos_pkg::P_RUN;
			end
		end
		default: pst_nxt = slide_pos_pkg::P_OFF;
		endcase
	end

	// motor drive: return, jog, then automatic positioning
	always_comb begin
		inc_want = 1'b0;
		dec_want = 1'b0;
		if (ret_r) begin
			dec_want = pos_r > min_lim_r;
		end else if (ctrl_r.jog_inc || ctrl_r.jog_dec) begin
			inc_want = ctrl_r.jog_inc && !ctrl_r.jog_dec;
			dec_want = ctrl_r.jog_dec && !ctrl_r.jog_inc;
		end else if (ctrl_r.auto_mode && calib_r) begin
			inc_want = 17'(pos_r) + 17'(slide_pos_pkg::DEADBAND) < 17'(target_r);
			dec_want = 17'(pos_r) > 17'(target_r) + 17'(slide_pos_pkg::DEADBAND);
		end
		inc_nxt = powered && sensor_pwr_ok && inc_want && (bypass || pos_r < max_lim_r);
		dec_nxt = powered && sensor_pwr_ok && dec_want && (bypass || pos_r > min_lim_r);
	end

	// led: fast flash waiting for minimum, slow for maximum
	always_comb begin
		led_cnt_nxt = led_cnt_r + 32'h00000001;
		led_nxt     = led;
		unique case (cst_r)
		slide_pos_pkg::C_MIN: begin
			if (led_cnt_r >= 32'(FAST_CYC - 1)) begin
				led_cnt_nxt = 32'h00000000;
				led_nxt     = !led;
			end
		end
		slide_pos_pkg::C_MAX: begin
			if (led_cnt_r >= 32'(SLOW_CYC - 1)) begin
				led_cnt_nxt = 32'h00000000;
				led_nxt     = !led;
			end
		end
		default: begin
			led_cnt_nxt = 32'h00000000;
			led_nxt     = 1'b0;
		end
		endcase
		if (cst_nxt != cst_r) begin
			led_cnt_nxt = 32'h00000000;
			led_nxt     = cst_nxt != slide_pos_pkg::C_IDLE;
		end
		// clamp to the analog span
		if (dac_q < 0)
			dac_nxt = 12'h000;
		else if (dac_q > slide_pos_pkg::DAC_FULL)
			dac_nxt = 12'hFFF;
		else
			dac_nxt = dac_q[11:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= '0;
			target_r  <= slide_pos_pkg::MIN_RST;
			min_ep_r  <= slide_pos_pkg::MIN_RST;
			max_ep_r  <= slide_pos_pkg::MAX_RST;
			min_lim_r <= slide_pos_pkg::MIN_RST;
			max_lim_r <= slide_pos_pkg::MAX_RST;
			cst_r     <= slide_pos_pkg::C_IDLE;
			pst_r     <= slide_pos_pkg::P_OFF;
			pos_r     <= 16'h0000;
			quiet_r   <= 32'h00000000;
			hold_r    <= 32'h00000000;
			led_cnt_r <= 32'h00000000;
			lost_r    <= 1'b0;
			calib_r   <= 1'b0;
			ret_r     <= 1'b0;
			btn_q_r   <= 1'b0;
			pct_r     <= 16'h0000;
			led       <= 1'b0;
			pos_out   <= 12'h000;
			motor_inc <= 1'b0;
			motor_dec <= 1'b0;
			nvm_wr    <= 1'b0;
			nvm_rd    <= 1'b0;
			nvm_wdata <= 16'h0000;
			pready    <= 1'b0;
			prdata    <= 32'h00000000;
			pslverr   <= 1'b0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			target_r  <= target_nxt;
			min_ep_r  <= min_ep_nxt;
			max_ep_r  <= max_ep_nxt;
			min_lim_r <= min_lim_nxt;
			max_lim_r <= max_lim_nxt;
			cst_r     <= cst_nxt;
			pst_r     <= pst_nxt;
			pos_r     <= pos_nxt;
			quiet_r   <= quiet_nxt;
			hold_r    <= hold_nxt;
			led_cnt_r <= led_cnt_nxt;
			lost_r    <= lost_nxt;
			calib_r   <= calib_nxt;
			ret_r     <= ret_nxt;
			btn_q_r   <= cal_btn;
			if (pct_done)
				pct_r <= pct_q[15:0];
			led       <= led_nxt;
			if (dac_done)
				pos_out <= dac_nxt;
			motor_inc <= inc_nxt;
			motor_dec <= dec_nxt;
			nvm_wr    <= wr_nxt;
			nvm_rd    <= rd_nxt;
			nvm_wdata <= wdata_nxt;
			pready    <= rdy_nxt;
			prdata    <= rdata_nxt;
			pslverr   <= err_nxt;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_third;
		cst_r == slide_pos_pkg::C_MAX && press && powered;
	endsequence
	sequence s_save;
		pst_r == slide_pos_pkg::P_SAVE ##1 nvm_wr && nvm_wdata == $past(pos_r) ##1 !nvm_wr;
	endsequence

	chk_pwr_cut: assert property (!sensor_pwr_ok |=> !motor_inc && !motor_dec)
		else $error("motor driven without sensor power");
	chk_dec_release: assert property (!ctrl_r.jog_dec && !ret_r && !ctrl_r.auto_mode
		|=> !motor_dec)
		else $error("decrease output on without command");
	chk_inc_release: assert property (!ctrl_r.jog_inc && !ctrl_r.auto_mode |=> !motor_inc)
		else $error("increase output on without command");
	chk_first_press: assert property (cst_r == slide_pos_pkg::C_IDLE && press && powered
		|=> cst_r == slide_pos_pkg::C_MIN ##1 led)
		else $error("calibration not entered");
	chk_min_store: assert property (cst_r == slide_pos_pkg::C_MIN && press && powered
		|=> min_ep_r == $past(pos_r) && cst_r == slide_pos_pkg::C_MAX)
		else $error("minimum end point not stored");
	chk_max_store: assert property (s_third |=> max_ep_r == $past(pos_r) && calib_r
		##1 !led)
		else $error("maximum end point not stored");
	chk_soft_lim: assert property (s_third |=> min_lim_r == min_ep_r + $past(lim_off)
		&& max_lim_r == max_ep_r - $past(lim_off))
		else $error("soft limits not 150mV inside");
	chk_save_pos: assert property (pst_r == slide_pos_pkg::P_SAVE |-> s_save)
		else $error("position not saved");
	chk_reload: assert property (pst_r == slide_pos_pkg::P_LOAD && nvm_rd_valid
		|=> pos_r == $past(nvm_rd_data) && pst_r == slide_pos_pkg::P_RUN)
		else $error("position not reloaded");
	chk_lost_cal: assert property (pst_r == slide_pos_pkg::P_OFF && sensor_pwr_ok && lost_r
		|=> cst_r == slide_pos_pkg::C_MIN && !calib_r)
		else $error("lost position did not force calibration");
	chk_return_min: assert property ($fell(ctrl_r.screen_cal) |-> ret_r)
		else $error("no return after calibration screen");
endmodule
`default_nettype wire

// file: slide_plant.sv
// partner model: gear-motor shaft, turn sensor and nonvolatile word
// assumes motor levels and store strobes registered on pclk
`timescale 1ns/1ps
`default_nettype none
module slide_plant (
	// clock
	input  wire logic        pclk,
	// motor drive and fault control
	input  wire logic        motor_inc,
	input  wire logic        motor_dec,
	input  wire logic        coast,
	input  wire logic [3:0]  rd_lat,
	// store side
	input  wire logic        nvm_wr,
	input  wire logic [15:0] nvm_wdata,
	input  wire logic        nvm_rd,
	output logic [15:0]      nvm_rd_data,
	output logic             nvm_rd_valid,
	// sensor pulses and true shaft position
	output logic             turn_up,
	output logic             turn_dn,
	output logic [15:0]      shaft
);
	logic [15:0] stored;
	logic [3:0]  wait_r;
	initial begin
		{turn_up, turn_dn, nvm_rd_valid} = 3'h0;
		shaft = 16'h0100;
		stored = 16'h0100;
		wait_r = 4'h0;
	end
	// a failed brake (coast) keeps the shaft turning up with no drive
	always @(posedge pclk) begin
		turn_up <= motor_inc | coast;
		turn_dn <= motor_dec & ~coast;
		if (turn_up & ~turn_dn)
			shaft <= shaft + 16'h0001;
		else if (turn_dn & ~turn_up)
			shaft <= shaft - 16'h0001;
	end
	// store answers after rd_lat cycles, slow or prompt
	always @(posedge pclk) begin
		if (nvm_wr)
			stored <= nvm_wdata;
		if (nvm_rd)
			wait_r <= rd_lat;
		else if (wait_r != 4'h0)
			wait_r <= wait_r - 4'h1;
		nvm_rd_valid <= (wait_r == 4'h1);
	end
	// idle data lines show the inverse, never a stale copy
	assign nvm_rd_data = nvm_rd_valid ? stored : ~stored;
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for slide_pos with the plant model
// assumes the shortened sim counts 8/40/4/8 set below
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pwr_ok = 1'b1;
	logic        btn = 1'b0;
	logic        coast = 1'b0;
	logic [3:0]  rd_lat = 4'h2;
	logic        turn_up, turn_dn, led, motor_inc, motor_dec, led_seen;
	logic        nvm_wr, nvm_rd, nvm_rd_valid;
	logic [15:0] nvm_wdata, nvm_rd_data, shaft;
	logic [63:0] rd_q[$];
	logic [15:0] nvm_q[$];
	logic [63:0] note;
	int          fail_count = 0;
	int          check_count = 0;
	int          mne, mxe, mnl, mxl, off, tgt, n;

	// 20 MHz clock
	always #25 pclk = ~pclk;

	slide_pos #(.STOP_CYC(8), .HOLD_CYC(40), .FAST_CYC(4), .SLOW_CYC(8)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sensor_pwr_ok(pwr_ok), .turn_up(turn_up),
		.turn_dn(turn_dn), .cal_btn(btn), .led(led), .pos_out(),
		.motor_inc(motor_inc), .motor_dec(motor_dec), .nvm_wr(nvm_wr),
		.nvm_wdata(nvm_wdata), .nvm_rd(nvm_rd), .nvm_rd_data(nvm_rd_data),
		.nvm_rd_valid(nvm_rd_valid));

	slide_plant plant (
		.pclk(pclk), .motor_inc(motor_inc), .motor_dec(motor_dec), .coast(coast),
		.rd_lat(rd_lat), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .nvm_rd(nvm_rd),
		.nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
		.turn_up(turn_up), .turn_dn(turn_dn), .shaft(shaft));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; a read notes {mask, expected}, mask 0 means unchecked
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] m);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			rd_q.push_back({m, d});
		@(posedge pclk);
		penable <= 1'b1;
		// hold the request until pready is seen high at a rising edge
		do begin
			@(posedge pclk);
		end while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
	endtask

	// motor levels as {inc, dec}, given one edge of latency plus margin
	task automatic motor_is(input logic [1:0] e);
		tick(2);
		@(negedge pclk);
		check(32'({motor_inc, motor_dec}), 32'(e));
	endtask

	task automatic press();
		@(posedge pclk);
		btn <= 1'b1;
		tick(2);
		@(negedge pclk);
		led_seen = led;
		tick(1);
		btn <= 1'b0;
		tick(3);
	endtask

	task automatic jog(input logic [31:0] c, input int k);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, c, 32'h0);
		tick(k);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h0, 32'h0);
		tick(4);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// oldest note is taken off whenever a read or a save appears
	always @(negedge pclk) begin
		if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
			note = rd_q.pop_front();
			check(prdata & note[63:32], note[31:0] & note[63:32]);
		end
		// 8'h40 is the only unmapped address the bench uses
		if (psel && penable && pready)
			check(32'(pslverr), 32'(paddr == 8'h40));
		if (nvm_wr && nvm_q.size() > 0)
			check(32'(nvm_wdata), 32'(nvm_q.pop_front()));
	end

	// hang guard, well above the expected run length
	initial begin
		tick(20000);
		fail_count++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'h345C));
		tick(20);
		presetn <= 1'b1;
		tick(12);
		apb(1'b0, slide_pos_pkg::OFS_POS, 32'(shaft), 32'hFFFF);
		apb(1'b0, slide_pos_pkg::OFS_MAX_LIM, 32'hFFFF, 32'hFFFFFFFF);
		apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		for (int i = 1; i <= 3; i++) begin
			apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'(i), 32'h0);
			motor_is((i == 3) ? 2'b00 : 2'(i));
			apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h0, 32'h0);
			motor_is(2'b00);
		end
		$display("test jog done");
		press();
		check(32'(led_seen), 32'h1);
		apb(1'b0, slide_pos_pkg::OFS_STATUS, 32'h1, 32'h3);
		jog(32'h1, $urandom_range(10, 30));
		mne = shaft;
		press();
		apb(1'b0, slide_pos_pkg::OFS_STATUS, 32'h2, 32'h3);
		apb(1'b0, slide_pos_pkg::OFS_MIN_EP, 32'(mne), 32'hFFFF);
		jog(32'h2, $urandom_range(100, 200));
		mxe = shaft;
		press();
		check(32'(led_seen), 32'h0);
		off = (mxe - mne) * 150 / 5000;
		mnl = mne + off;
		mxl = mxe - off;
		apb(1'b0, slide_pos_pkg::OFS_MAX_EP, 32'(mxe), 32'hFFFF);
		apb(1'b0, slide_pos_pkg::OFS_MIN_LIM, 32'(mnl), 32'hFFFF);
		apb(1'b0, slide_pos_pkg::OFS_MAX_LIM, 32'(mxl), 32'hFFFF);
		apb(1'b0, slide_pos_pkg::OFS_STATUS, 32'h8, 32'hB);
		tick(40);
		apb(1'b0, slide_pos_pkg::OFS_PCT, 32'((mxe - mnl) * 1000 / (mxl - mnl)),
			32'hFFFFFFFF);
		apb(1'b0, slide_pos_pkg::OFS_DAC, 32'hFFF, 32'hFFF);
		$display("test calibration done");
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h2, 32'h0);
		motor_is(2'b00);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h6, 32'h0);
		motor_is(2'b10);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h4, 32'h0);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h0, 32'h0);
		motor_is(2'b01);
		n = 0;
		while (motor_dec && n < 2000) begin
			tick(1);
			n++;
		end
		tick(4);
		check(32'(shaft <= mnl), 32'h1);
		$display("test screen calibration done");
		// automatic positioning only drives a calibrated actuator
		tgt = shaft + 30 + $urandom_range(0, 20);
		apb(1'b1, slide_pos_pkg::OFS_TARGET, 32'(tgt), 32'h0);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h8, 32'h0);
		motor_is(2'b10);
		n = 0;
		while (motor_inc && n < 500) begin
			tick(1);
			n++;
		end
		tick(4);
		check(32'(shaft >= tgt - 3 && shaft <= tgt + 3), 32'h1);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h0, 32'h0);
		$display("test auto done");
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h2, 32'h0);
		motor_is(2'b10);
		tick(1);
		pwr_ok <= 1'b0;
		motor_is(2'b00);
		tick(3);
		nvm_q.push_back(shaft);
		apb(1'b1, slide_pos_pkg::OFS_CTRL, 32'h0, 32'h0);
		tick(30);
		check(32'(nvm_q.size()), 32'h0);
		rd_lat <= 4'h6;
		pwr_ok <= 1'b1;
		tick(20);
		apb(1'b0, slide_pos_pkg::OFS_POS, 32'(shaft), 32'hFFFF);
		$display("test power save done");
		coast <= 1'b1;
		pwr_ok <= 1'b0;
		tick(60);
		coast <= 1'b0;
		pwr_ok <= 1'b1;
		tick(10);
		apb(1'b0, slide_pos_pkg::OFS_STATUS, 32'h1, 32'h1);
		$display("test lost position done");
		end_of_test();
	end
endmodule
`default_nettype wire
